/* File: bench/i2c_master_model.sv */
// Behavioural two-wire bus master that drives the sensor's serial pins
`timescale 1ns/1ns
`default_nettype none
`include "sensor_cfg_defines.svh"

module i2c_master_model (
  input wire logic sys_clk, // Bench clock, paces the bit slots
  output logic sclOut, // Serial clock, idles high between frames
  output logic sdaPull, // High pulls the data line low
  input wire logic sdaLine // Resolved data line level
);
  // Clock stands high and data is released while no frame runs
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end

  // Every change lands just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Slot of 8 cycles low and 8 high, twice the minimum phase the target needs
  task automatic bit_slot(input logic b, output logic seen);
    sclOut = 1'b0;
    tick(2);
    sdaPull = ~b;
    tick(6);
    sclOut = 1'b1;
    tick(4);
    seen = sdaLine; // Sampled mid-high, long after the target's 3-cycle answer
    tick(4);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sclOut = 1'b0;
    tick(2);
    sdaPull = 1'b0;
    tick(6);
    sclOut = 1'b1;
    tick(8);
    sdaPull = 1'b1;
    tick(8);
  endtask

  // Stop: data rises while the clock is high, then the bus rests
  task automatic stop_cond();
    sclOut = 1'b0;
    tick(2);
    sdaPull = 1'b1;
    tick(6);
    sclOut = 1'b1;
    tick(8);
    sdaPull = 1'b0;
    tick(8);
  endtask

  // Byte out MSB first, then the target's acknowledge slot with data released
  task automatic send_byte(input logic [7:0] d, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], s);
    end
    bit_slot(1'b1, nak);
  endtask

  // Byte in MSB first, then our own acknowledge or not-acknowledge
  task automatic recv_byte(input logic nakOut, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, d[i]);
    end
    bit_slot(nakOut, s);
  endtask

  // Register write: only the documented write command is ever used
  task automatic reg_write(input logic [7:0] d, output logic [2:0] nak);
    start_cond();
    send_byte({`TARGET_ADDR, 1'b0}, nak[2]);
    send_byte(`CMD_WRITE_CFG, nak[1]);
    send_byte(d, nak[0]);
    stop_cond();
  endtask

  // Read first, then write back every bit but the resolution field as it was read
  task automatic reg_modify(input logic [1:0] code, output logic [7:0] d,
                            output logic [2:0] nak);
    logic [2:0] rdNak;
    reg_read(d, rdNak);
    reg_write({code[1], d[6:1], code[0]}, nak);
    nak = nak | rdNak;
  endtask

  // Register read: one byte, refused with a not-acknowledge, no checksum
  task automatic reg_read(output logic [7:0] d, output logic [2:0] nak);
    start_cond();
    send_byte({`TARGET_ADDR, 1'b0}, nak[2]);
    send_byte(`CMD_READ_CFG, nak[1]);
    start_cond();
    send_byte({`TARGET_ADDR, 1'b1}, nak[0]);
    recv_byte(1'b1, d);
    stop_cond();
  endtask
endmodule

`default_nettype wire

/* File: bench/sensor_user_config_register_bench.sv */
// Self-checking bench for the sensor user configuration register
`timescale 1ns/1ns
`default_nettype none
`include "sensor_cfg_defines.svh"

module sensor_user_config_register_bench
  import sensor_cfg_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclIn, sdaOut, sdaOe, mstPull, supplyLow, convStart, convDone, convBusy;
  logic [1:0] convResolution;
  logic [3:0] convWidth;
  wire sdaLine;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Open drain with pull-up: low when either party pulls
  assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~mstPull;

  always #10 sys_clk = ~sys_clk;

  sensor_user_config_register u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .supplyLow(supplyLow), .convStart(convStart),
    .convDone(convDone), .convBusy(convBusy), .convResolution(convResolution),
    .convWidth(convWidth)
  );

  i2c_master_model u_master (
    .sys_clk(sys_clk), .sclOut(sclIn), .sdaPull(mstPull), .sdaLine(sdaLine)
  );

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // About 20 transactions of under 1000 cycles each; the ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      final_report();
    end
  end

  // One-cycle pulses toward the conversion side, entered just after an edge
  task automatic pulse_start();
    convStart = 1'b1;
    u_master.tick(1);
    convStart = 1'b0;
  endtask

  task automatic pulse_done();
    convDone = 1'b1;
    u_master.tick(1);
    convDone = 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] rd;
    logic [2:0] nak;
    logic [3:0] widthOf [4];
    logic [1:0] code;
    widthOf = '{`WIDTH_14, `WIDTH_12, `WIDTH_13, `WIDTH_11};
    supplyLow = 1'b0;
    convStart = 1'b0;
    convDone = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    check("reset resolution", {6'h00, convResolution}, 8'h00);
    check("reset width", {4'h0, convWidth}, {4'h0, `WIDTH_14});
    u_master.tick(4);
    u_master.reg_read(rd, nak);
    check("read acks", {5'h00, nak}, 8'h00);
    check("reset value", rd, `CFG_RESET);
    // Every code, with reserved bits inverted and the read-only flag set in the write
    for (int c = 0; c < 4; c++) begin
      code = c[1:0];
      u_master.reg_write({code[1], 1'b1, 5'b00010, code[0]}, nak);
      check("write acks", {5'h00, nak}, 8'h00);
      u_master.reg_read(rd, nak);
      check("reserved bits", rd & `CFG_RESERVED_BITS_MASK, `CFG_RESET & `CFG_RESERVED_BITS_MASK);
      check("supply flag", {7'h00, rd[6]}, 8'h00);
      check("resolution field", {6'h00, rd[7], rd[0]}, {6'h00, code});
      pulse_start();
      check("busy", {7'h00, convBusy}, 8'h01);
      check("conv code", {6'h00, convResolution}, {6'h00, code});
      check("conv width", {4'h0, convWidth}, {4'h0, widthOf[c]});
      pulse_done();
      check("idle", {7'h00, convBusy}, 8'h00);
    end
    // A write during a conversion must wait for the next one
    pulse_start();
    u_master.reg_modify(2'h1, rd, nak);
    check("modify acks", {5'h00, nak}, 8'h00);
    check("modify read", rd, 8'hbb);
    check("running code", {6'h00, convResolution}, 8'h03);
    check("running width", {4'h0, convWidth}, {4'h0, `WIDTH_11});
    pulse_done();
    pulse_start();
    check("next code", {6'h00, convResolution}, 8'h01);
    check("next width", {4'h0, convWidth}, {4'h0, `WIDTH_12});
    pulse_done();
    // Supply flag follows the low-band comparator
    supplyLow = 1'b1;
    u_master.reg_read(rd, nak);
    check("supply low", rd, 8'h7b);
    supplyLow = 1'b0;
    u_master.reg_read(rd, nak);
    check("supply ok", rd, 8'h3b);
    // Unlisted command is refused and changes nothing
    u_master.start_cond();
    u_master.send_byte({`TARGET_ADDR, 1'b0}, nak[2]);
    u_master.send_byte(8'h55, nak[1]);
    u_master.stop_cond();
    check("unknown command", {6'h00, nak[2:1]}, 8'h01);
    // Foreign address is never acknowledged
    u_master.start_cond();
    u_master.send_byte({`TARGET_ADDR ^ 7'h01, 1'b0}, nak[0]);
    u_master.stop_cond();
    check("foreign address", {7'h00, nak[0]}, 8'h01);
    // A second data byte is refused; only the first one lands
    u_master.start_cond();
    u_master.send_byte({`TARGET_ADDR, 1'b0}, nak[2]);
    u_master.send_byte(`CMD_WRITE_CFG, nak[1]);
    u_master.send_byte(8'h3a, nak[0]);
    check("three acks", {5'h00, nak}, 8'h00);
    u_master.send_byte(8'hbb, nak[0]);
    u_master.stop_cond();
    check("extra byte", {7'h00, nak[0]}, 8'h01);
    check("line released", {7'h00, sdaOe}, 8'h00);
    u_master.reg_read(rd, nak);
    check("after refusals", rd, 8'h3a);
    final_report();
  end
endmodule

`default_nettype wire

/* File: design/cfg_link_if.sv */
// Byte-level events between the link engine and the register logic
`timescale 1ns/1ns
`default_nettype none

interface cfg_link_if;
  logic startEv; // Start or repeated start seen
  logic stopEv; // Stop seen
  logic addrEv; // Own address matched
  logic addrRead; // Direction bit of that address
  logic rxEv; // Byte received from the master
  logic [7:0] rxByte; // The received byte
  logic ackData; // Acknowledge the current received byte
  logic [7:0] txByte; // Byte to send on a read

  modport target (
    output startEv, stopEv, addrEv, addrRead, rxEv, rxByte,
    input ackData, txByte
  );
  modport ctrl (
    input startEv, stopEv, addrEv, addrRead, rxEv, rxByte,
    output ackData, txByte
  );
endinterface

`default_nettype wire

/* File: design/i2c_target_link.sv */
// Two-wire target engine: start/stop, address match, byte shift and acknowledge
`timescale 1ns/1ns
`default_nettype none
`include "sensor_cfg_defines.svh"

module i2c_target_link
  import sensor_cfg_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic sclIn, // Serial clock pin level
  input wire logic sdaIn, // Serial data pin level
  output logic sdaOe, // Pull the data line low
  cfg_link_if.target link // Byte events toward the register logic
);

  logic sclSync1_ff, sclSync2_ff, sclPrev_ff;
  logic sdaSync1_ff, sdaSync2_ff, sdaPrev_ff;
  link_state_e state_ff, nxt_state;
  logic [3:0] bitCnt_ff, nxt_bitCnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] rxByte_ff, nxt_rxByte;
  logic oe_ff, nxt_oe, isAddr_ff, nxt_isAddr, read_ff, nxt_read;
  logic startEv_ff, nxt_startEv, stopEv_ff, nxt_stopEv;
  logic addrEv_ff, nxt_addrEv, rxEv_ff, nxt_rxEv;
  logic sclRise, sclFall, startSeen, stopSeen;

  // Edges are taken from the second stage only, never from the first
  assign sclRise = sclSync2_ff & ~sclPrev_ff;
  assign sclFall = ~sclSync2_ff & sclPrev_ff;
  assign startSeen = sclSync2_ff & sclPrev_ff & sdaPrev_ff & ~sdaSync2_ff;
  assign stopSeen = sclSync2_ff & sclPrev_ff & ~sdaPrev_ff & sdaSync2_ff;

  // ***************************************************
  // Bit sequencing
  // ***************************************************
  // Drive changes only on a falling clock so data is stable while the clock is high
  always_comb begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_rxByte = rxByte_ff;
    nxt_oe = oe_ff;
    nxt_isAddr = isAddr_ff;
    nxt_read = read_ff;
    nxt_startEv = 1'b0;
    nxt_stopEv = 1'b0;
    nxt_addrEv = 1'b0;
    nxt_rxEv = 1'b0;
    if (startSeen) begin
      nxt_state = L_ADDR;
      nxt_bitCnt = 4'h0;
      nxt_oe = 1'b0;
      nxt_startEv = 1'b1;
    end else if (stopSeen) begin
      nxt_state = L_IDLE;
      nxt_oe = 1'b0;
      nxt_stopEv = 1'b1;
    end else begin
      case (state_ff)
        L_ADDR, L_RX: begin
          if (sclRise) begin
            nxt_shift = {shift_ff[6:0], sdaSync2_ff};
            nxt_bitCnt = bitCnt_ff + 4'h1;
            if (bitCnt_ff == `BIT_LAST) begin
              nxt_bitCnt = 4'h0;
              nxt_isAddr = (state_ff == L_ADDR);
              nxt_state = L_ACK;
              if (state_ff == L_RX) begin
                nxt_rxEv = 1'b1;
                nxt_rxByte = {shift_ff[6:0], sdaSync2_ff};
              end else if (shift_ff[6:0] == `TARGET_ADDR) begin
                nxt_addrEv = 1'b1;
                nxt_read = sdaSync2_ff;
              end else begin
                nxt_state = L_IDLE; // Not ours: stay off the line
              end
            end
          end
        end
        L_ACK: begin
          if (sclFall && bitCnt_ff == 4'h0) begin
            nxt_oe = isAddr_ff | link.ackData; // R7 R8
            nxt_bitCnt = 4'h1;
          end else if (sclFall) begin
            nxt_bitCnt = 4'h0;
            nxt_oe = 1'b0;
            if (!oe_ff) begin
              nxt_state = L_IDLE;
            end else if (read_ff) begin
              nxt_state = L_TX;
              nxt_shift = link.txByte;
              nxt_oe = ~link.txByte[7];
            end else begin
              nxt_state = L_RX;
            end
          end
        end
        L_TX: begin
          if (sclRise) begin
            nxt_bitCnt = bitCnt_ff + 4'h1;
            if (bitCnt_ff == `BIT_LAST) begin
              nxt_state = L_TXACK;
              nxt_bitCnt = 4'h0;
            end
          end else if (sclFall) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_oe = ~shift_ff[6];
          end
        end
        L_TXACK: begin
          if (sclFall && bitCnt_ff == 4'h0) begin
            nxt_oe = 1'b0;
            nxt_bitCnt = 4'h1;
          end else if (sclRise && bitCnt_ff == 4'h1) begin
            nxt_bitCnt = 4'h2;
            if (sdaSync2_ff) begin
              nxt_state = L_IDLE; // Master refused: wait for stop
            end
          end else if (sclFall && bitCnt_ff == 4'h2) begin
            nxt_state = L_TX;
            nxt_bitCnt = 4'h0;
            nxt_shift = link.txByte;
            nxt_oe = ~link.txByte[7];
          end
        end
        default: nxt_state = L_IDLE;
      endcase
    end
  end

  // Registers, including the two-stage pin synchronisers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclSync1_ff <= 1'b1;
      sclSync2_ff <= 1'b1;
      sclPrev_ff <= 1'b1;
      sdaSync1_ff <= 1'b1;
      sdaSync2_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
      state_ff <= L_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rxByte_ff <= 8'h00;
      oe_ff <= 1'b0;
      isAddr_ff <= 1'b0;
      read_ff <= 1'b0;
      startEv_ff <= 1'b0;
      stopEv_ff <= 1'b0;
      addrEv_ff <= 1'b0;
      rxEv_ff <= 1'b0;
    end else begin
      sclSync1_ff <= sclIn;
      sclSync2_ff <= sclSync1_ff;
      sclPrev_ff <= sclSync2_ff;
      sdaSync1_ff <= sdaIn;
      sdaSync2_ff <= sdaSync1_ff;
      sdaPrev_ff <= sdaSync2_ff;
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      shift_ff <= nxt_shift;
      rxByte_ff <= nxt_rxByte;
      oe_ff <= nxt_oe;
      isAddr_ff <= nxt_isAddr;
      read_ff <= nxt_read;
      startEv_ff <= nxt_startEv;
      stopEv_ff <= nxt_stopEv;
      addrEv_ff <= nxt_addrEv;
      rxEv_ff <= nxt_rxEv;
    end
  end

  assign sdaOe = oe_ff;
  assign link.startEv = startEv_ff;
  assign link.stopEv = stopEv_ff;
  assign link.addrEv = addrEv_ff;
  assign link.addrRead = read_ff;
  assign link.rxEv = rxEv_ff;
  assign link.rxByte = rxByte_ff;

endmodule

`default_nettype wire

/* File: design/sensor_cfg_defines.svh */
// Constants of the sensor user configuration register and its serial link
`ifndef SENSOR_CFG_DEFINES_SVH
`define SENSOR_CFG_DEFINES_SVH

// Target address on the two-wire link; arbitrary value
`define TARGET_ADDR 7'h40
// Command codes; arbitrary values
`define CMD_WRITE_CFG 8'h01
`define CMD_READ_CFG 8'h02
// Register reset value and field positions
`define CFG_RESET 8'h3a
`define CFG_RES_HI_BIT 7
`define CFG_SUPPLY_BIT 6
`define CFG_RES_LO_BIT 0
// Bits that are fixed and ignore writes
`define CFG_RESERVED_BITS_MASK 8'h3e
// Resolution codes and the conversion widths they select
`define RES_CODE_14 2'h0
`define RES_CODE_12 2'h1
`define RES_CODE_13 2'h2
`define RES_CODE_11 2'h3
`define WIDTH_14 4'he
`define WIDTH_13 4'hd
`define WIDTH_12 4'hc
`define WIDTH_11 4'hb
// Last bit index within a byte
`define BIT_LAST 4'h7

`endif

/* File: design/sensor_cfg_pkg.sv */
// Types shared by the configuration register and its link engine
package sensor_cfg_pkg;

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_ADDR = 3'b001,
    L_ACK = 3'b010,
    L_RX = 3'b011,
    L_TX = 3'b100,
    L_TXACK = 3'b101
  } link_state_e;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_CMD = 2'b01,
    T_WDATA = 2'b10,
    T_DONE = 2'b11
  } txn_state_e;

endpackage

/* File: design/sensor_user_config_register.sv */
// User configuration and status register of the temperature sensor
// Rules for this block and for the master that talks to it
// [R1] Resolution code is bit 7 high, bit 0 low: 00=14, 01=12, 10=13, 11=11 bits.
// [R2] Bit 6 is read-only; reads 1 while supply sits in the low band.
// [R3] Register resets to 0011_1010: 14-bit resolution, supply flag clear.
// [R4] Reserved bits keep their fixed value and ignore every write.
// [R5] Master writes no other location; other reads are undefined.
// [R6] Master reads first and writes reserved bits back unchanged.
// [R7] Read: address+W, read command, repeated start, address+R, one byte, NACK, stop.
// [R8] Write: address+W, write command, data byte, stop; all three bytes acknowledged.
// [R9] New resolution applies to later conversions; a running one keeps its own.
`timescale 1ns/1ns
`default_nettype none
`include "sensor_cfg_defines.svh"

module sensor_user_config_register
  import sensor_cfg_pkg::*;
(
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic sclIn, // Serial clock pin
  input wire logic sdaIn, // Serial data pin, input side
  output logic sdaOut, // Serial data pin, output level
  output logic sdaOe, // Serial data pin, drive enable
  input wire logic supplyLow, // Supply comparator, high in the low band
  input wire logic convStart, // Conversion start request, one cycle
  input wire logic convDone, // Conversion finished, one cycle
  output logic convBusy, // Conversion in progress
  output logic [1:0] convResolution, // Code latched for the running conversion
  output logic [3:0] convWidth // Bits of the running conversion
);

  cfg_link_if link();

  i2c_target_link u_link (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOe(sdaOe),
    .link(link)
  );

  txn_state_e txn_ff, nxt_txn;
  logic resHi_ff, nxt_resHi, resLo_ff, nxt_resLo;
  logic supplySync1_ff, supplySync2_ff, supplyLowFlag_ff, nxt_supplyLowFlag;
  logic busy_ff, nxt_busy;
  logic ackLast_ff, nxt_ackLast;
  logic [1:0] convRes_ff, nxt_convRes;
  logic [3:0] width_ff, nxt_width;
  logic [7:0] regValue;

  // Map a resolution code to the conversion width
  function automatic logic [3:0] res_width(input logic [1:0] code);
    case (code)
      `RES_CODE_14: res_width = `WIDTH_14; // R1
      `RES_CODE_12: res_width = `WIDTH_12;
      `RES_CODE_13: res_width = `WIDTH_13;
      default: res_width = `WIDTH_11;
    endcase
  endfunction

  // ***************************************************
  // Register image
  // ***************************************************
  // Reserved bits come from the reset pattern so they never drift
  always_comb begin
    regValue = `CFG_RESET & `CFG_RESERVED_BITS_MASK; // R4
    regValue[`CFG_RES_HI_BIT] = resHi_ff; // R1
    regValue[`CFG_SUPPLY_BIT] = supplyLowFlag_ff; // R2
    regValue[`CFG_RES_LO_BIT] = resLo_ff;
  end

  // Reads always return the register; other locations are undefined anyway
  assign link.txByte = regValue;
  // Acknowledge decided when the byte arrived; the state has moved on by the ack slot
  assign link.ackData = ackLast_ff; // R7 R8
  assign sdaOut = 1'b0;

  // ***************************************************
  // Transaction and conversion control
  // ***************************************************
  // Unknown commands are refused so the master sees a NACK
  always_comb begin
    nxt_txn = txn_ff;
    nxt_resHi = resHi_ff;
    nxt_resLo = resLo_ff;
    nxt_supplyLowFlag = supplySync2_ff; // R2
    nxt_busy = busy_ff;
    nxt_ackLast = ackLast_ff;
    nxt_convRes = convRes_ff;
    nxt_width = width_ff;
    if (link.startEv || link.stopEv) begin
      nxt_txn = T_IDLE;
    end else if (link.addrEv) begin
      nxt_txn = link.addrRead ? T_DONE : T_CMD; // R7
    end else if (link.rxEv) begin
      case (txn_ff)
        T_CMD: begin
          nxt_ackLast = (link.rxByte == `CMD_WRITE_CFG) || (link.rxByte == `CMD_READ_CFG); // R7 R8
          if (link.rxByte == `CMD_WRITE_CFG) begin
            nxt_txn = T_WDATA; // R8
          end else begin
            nxt_txn = T_DONE; // R7
          end
        end
        T_WDATA: begin
          nxt_ackLast = 1'b1; // R8
          nxt_resHi = link.rxByte[`CFG_RES_HI_BIT]; // R8
          nxt_resLo = link.rxByte[`CFG_RES_LO_BIT];
          nxt_txn = T_DONE;
        end
        default: begin
          nxt_ackLast = 1'b0; // R8
          nxt_txn = T_DONE;
        end
      endcase
    end
    // Latch the code at start so a write mid-conversion cannot disturb it
    if (convStart && !busy_ff) begin
      nxt_busy = 1'b1;
      nxt_convRes = {resHi_ff, resLo_ff}; // R9
      nxt_width = res_width({resHi_ff, resLo_ff}); // R1
    end else if (convDone) begin
      nxt_busy = 1'b0;
    end
  end

  // Registers; the supply input crosses in through two stages
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txn_ff <= T_IDLE;
      resHi_ff <= 1'(`CFG_RESET >> `CFG_RES_HI_BIT); // R3
      resLo_ff <= 1'(`CFG_RESET >> `CFG_RES_LO_BIT);
      ackLast_ff <= 1'b0;
      supplySync1_ff <= 1'b0;
      supplySync2_ff <= 1'b0;
      supplyLowFlag_ff <= 1'b0;
      busy_ff <= 1'b0;
      convRes_ff <= `RES_CODE_14;
      width_ff <= `WIDTH_14;
    end else begin
      txn_ff <= nxt_txn;
      resHi_ff <= nxt_resHi;
      resLo_ff <= nxt_resLo;
      supplySync1_ff <= supplyLow;
      supplySync2_ff <= supplySync1_ff;
      supplyLowFlag_ff <= nxt_supplyLowFlag;
      busy_ff <= nxt_busy;
      ackLast_ff <= nxt_ackLast;
      convRes_ff <= nxt_convRes;
      width_ff <= nxt_width;
    end
  end

  assign convBusy = busy_ff;
  assign convResolution = convRes_ff;
  assign convWidth = width_ff;

  // ***************************************************
  // Assertions
  // ***************************************************
  property p_width_map;
    @(posedge sys_clk) disable iff (sys_rst)
      (convStart && !busy_ff) |=> convWidth == res_width($past({resHi_ff, resLo_ff}));
  endproperty
  a_width_map: assert property (p_width_map) // R1
    else $error("conversion width does not follow resolution code");

  property p_supply_flag;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(supplyLow) ##1 supplyLow[*2] |=> regValue[`CFG_SUPPLY_BIT];
  endproperty
  a_supply_flag: assert property (p_supply_flag) // R2
    else $error("supply flag did not rise three cycles after low supply");

  property p_reset_value;
    @(posedge sys_clk) disable iff (sys_rst)
      $past(sys_rst) |-> regValue == `CFG_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) // R3
    else $error("register differs from reset pattern after reset");

  property p_reserved;
    @(posedge sys_clk) disable iff (sys_rst)
      (regValue & `CFG_RESERVED_BITS_MASK) == (`CFG_RESET & `CFG_RESERVED_BITS_MASK);
  endproperty
  a_reserved: assert property (p_reserved) // R4
    else $error("reserved bits changed");

  property p_read_cmd;
    @(posedge sys_clk) disable iff (sys_rst)
      (link.rxEv && txn_ff == T_CMD && link.rxByte == `CMD_READ_CFG)
        |=> txn_ff == T_DONE && $stable({resHi_ff, resLo_ff});
  endproperty
  a_read_cmd: assert property (p_read_cmd) // R7
    else $error("read command altered register or state");

  property p_write_data;
    @(posedge sys_clk) disable iff (sys_rst)
      (link.rxEv && txn_ff == T_WDATA && !link.startEv && !link.stopEv)
        |=> resHi_ff == $past(link.rxByte[7]) && resLo_ff == $past(link.rxByte[0]);
  endproperty
  a_write_data: assert property (p_write_data) // R8
    else $error("written resolution bits not stored");

  property p_hold_res;
    @(posedge sys_clk) disable iff (sys_rst)
      (busy_ff && !convDone) |=> $stable(convResolution) && $stable(convWidth);
  endproperty
  a_hold_res: assert property (p_hold_res) // R9
    else $error("resolution changed during a conversion");

endmodule

`default_nettype wire
